/* shared/isx_pkg.sv */
// Shared constants and types for the increment-skip / OR-literal execution block
package isx_pkg;

   // ==========================================================
   // Register map (byte addresses, one 32-bit word each)
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_NEXT = 8'h04;
   localparam logic [7:0] REG_ACC = 8'h08;
   localparam logic [7:0] REG_FLAGS = 8'h0C;
   localparam logic [7:0] REG_BANK = 8'h10;
   localparam logic [7:0] REG_INDEX = 8'h14;
   localparam logic [7:0] REG_CTRL = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1C;
   localparam logic [7:0] REG_MADDR = 8'h20;
   localparam logic [7:0] REG_MDATA = 8'h24;

   // ==========================================================
   // Field positions and reset values
   localparam int FLAG_N = 4;
   localparam int FLAG_Z = 2;
   localparam int CTRL_EXT = 0;
   localparam int ST_BUSY = 0;
   localparam int ST_SKIP = 1;
   localparam int ST_ILLEGAL = 2;
   localparam int ST_INDEXED = 3;
   localparam int ST_CYC_LO = 4;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [11:0] RST_ADDR = 12'h000;

   // ==========================================================
   // Opcode patterns and access bank limits
   localparam logic [5:0] OPC_INC_SKIP = 6'h12;
   localparam logic [7:0] OPC_OR_LIT = 8'h09;
   localparam logic [3:0] OPC_TWO_A = 4'hC;
   localparam logic [5:0] OPC_TWO_B = 6'h3B;
   localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

   // ==========================================================
   // Timing: four quarter phases per instruction cycle
   localparam logic [1:0] Q_FIRST = 2'h0;
   localparam logic [1:0] Q_READ = 2'h1;
   localparam logic [1:0] Q_PROC = 2'h2;
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [1:0] NOP_ONE = 2'h1;
   localparam logic [1:0] NOP_TWO = 2'h2;
   localparam logic [1:0] CYC_ONE = 2'h1;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} isx_state_t;

   typedef struct packed {
      logic is_inc;
      logic is_or;
      logic dest;
      logic access;
      logic two_word_next;
      logic [7:0] lit;
   } isx_dec_t;

endpackage

/* verif/increment_skip_and_or_literal_exec_tb.sv */
// Self-checking bench for the increment-skip and OR-literal execution block
`timescale 1ns/1ps
module increment_skip_and_or_literal_exec_tb;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic busy;
   logic [31:0] rd;
   int err_total = 0;
   int n_checks = 0;
   logic [15:0] two_w [2] = '{16'hC123, 16'hEC00};
   logic [7:0] ix_hi [4] = '{8'h4A, 8'h4A, 8'h4A, 8'h4B};
   logic [7:0] ix_f [4] = '{8'h20, 8'h5F, 8'h60, 8'h20};
   logic [11:0] ix_a [4] = '{12'h220, 12'h25F, 12'hF60, 12'h320};
   logic [7:0] or_a [3] = '{8'h9A, 8'h00, 8'h41};
   logic [7:0] or_k [3] = '{8'h35, 8'h00, 8'h02};
   logic [7:0] or_f [3] = '{8'h0B, 8'h10, 8'hEF};
   logic [7:0] e_acc;
   logic [7:0] e_fl;

   always #2.5 ref_clk = ~ref_clk;

   isx_exec uut
   (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .busy(busy)
   );

   // ==========================================================
   // Bus and compare helpers
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One edge first so a release and a new raise never share a time step
   task bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= is_wr;
      avs_read <= ~is_wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 2000)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 2000)
         check("bus answer", {31'h0, avs_waitrequest}, 32'h0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask

   task mem_set(input logic [11:0] a, input logic [7:0] v);
      wr(isx_pkg::REG_MADDR, {20'h0, a});
      wr(isx_pkg::REG_MDATA, {24'h0, v});
   endtask

   task mem_chk(input string what, input logic [11:0] a, input logic [7:0] e);
      wr(isx_pkg::REG_MADDR, {20'h0, a});
      rdc(what, isx_pkg::REG_MDATA, {24'h0, e});
   endtask

   task run(input logic [15:0] ins, input logic [15:0] nxt);
      int n;
      n = 0;
      wr(isx_pkg::REG_NEXT, {16'h0, nxt});
      wr(isx_pkg::REG_INSTR, {16'h0, ins});
      while (busy === 1'b1 && n < 100)
      begin
         @(posedge ref_clk);
         n++;
      end
   endtask

   task done(input string name);
      $display("test %s finished, mismatches so far %0d", name, err_total);
   endtask

   // ==========================================================
   // Tests
   initial
   begin
      repeat (8) @(posedge ref_clk);
      check("waitrequest in reset", {31'h0, avs_waitrequest}, 32'h1);
      check("busy in reset", {31'h0, busy}, 32'h0);
      sys_rst <= 1'b0;
      rdc("acc reset", isx_pkg::REG_ACC, 32'h0);
      rdc("flags reset", isx_pkg::REG_FLAGS, 32'h0);
      // Cycle field never reads zero: reset shows one cycle
      rdc("status reset", isx_pkg::REG_STATUS, 32'h10);
      wr(8'h40, 32'hFF);
      rdc("unmapped", 8'h40, 32'h0);
      done("reset");

      wr(isx_pkg::REG_BANK, 32'h3);
      mem_set(12'h340, 8'h7E);
      wr(isx_pkg::REG_FLAGS, 32'h14);
      wr(isx_pkg::REG_ACC, 32'h55);
      run(16'h4B40, 16'h0000);
      mem_chk("banked file", 12'h340, 8'h7F);
      rdc("acc kept", isx_pkg::REG_ACC, 32'h55);
      rdc("flags kept", isx_pkg::REG_FLAGS, 32'h14);
      rdc("status skip", isx_pkg::REG_STATUS, 32'h22);
      done("skip to file");

      // Zero result must neither skip nor touch the zero flag
      mem_set(12'hF60, 8'hFF);
      wr(isx_pkg::REG_FLAGS, 32'h0);
      run(16'h4860, 16'hC000);
      rdc("acc wrap", isx_pkg::REG_ACC, 32'h0);
      mem_chk("file kept", 12'hF60, 8'hFF);
      rdc("flags wrap", isx_pkg::REG_FLAGS, 32'h0);
      rdc("status no skip", isx_pkg::REG_STATUS, 32'h10);
      done("wrap to acc");

      for (int i = 0; i < 2; i++)
      begin
         mem_set(12'h010, 8'h05);
         run(16'h4A10, two_w[i]);
         mem_chk("access bank", 12'h010, 8'h06);
         rdc("status two word", isx_pkg::REG_STATUS, 32'h32);
      end
      done("two word skip");

      wr(isx_pkg::REG_CTRL, 32'h1);
      wr(isx_pkg::REG_INDEX, 32'h200);
      for (int i = 0; i < 4; i++)
      begin
         mem_set(ix_a[i], 8'h10);
         run({ix_hi[i], ix_f[i]}, 16'h0000);
         mem_chk("indexed file", ix_a[i], 8'h11);
         rdc("status indexed", isx_pkg::REG_STATUS, (i < 2) ? 32'h2A : 32'h22);
      end
      wr(isx_pkg::REG_CTRL, 32'h0);
      done("indexed");

      for (int i = 0; i < 3; i++)
      begin
         e_acc = or_a[i] | or_k[i];
         e_fl = (or_f[i] & 8'hEB) | {3'h0, e_acc[7], 1'b0, e_acc == 8'h00, 2'h0};
         wr(isx_pkg::REG_ACC, {24'h0, or_a[i]});
         wr(isx_pkg::REG_FLAGS, {24'h0, or_f[i]});
         run({8'h09, or_k[i]}, 16'hC000);
         rdc("or acc", isx_pkg::REG_ACC, {24'h0, e_acc});
         rdc("or flags", isx_pkg::REG_FLAGS, {24'h0, e_fl});
         rdc("or status", isx_pkg::REG_STATUS, 32'h10);
      end
      done("or literal");

      // Unknown opcode runs as a one-cycle no-op and leaves the accumulator alone
      run(16'hFFFF, 16'h0000);
      rdc("illegal acc", isx_pkg::REG_ACC, 32'h43);
      rdc("illegal status", isx_pkg::REG_STATUS, 32'h14);
      done("illegal opcode");

      // Accumulator write lands while the skip still runs; it must wait, not vanish
      mem_set(12'h010, 8'h01);
      wr(isx_pkg::REG_NEXT, 32'h0);
      wr(isx_pkg::REG_INSTR, 32'h4810);
      wr(isx_pkg::REG_ACC, 32'hA5);
      rdc("acc after stall", isx_pkg::REG_ACC, 32'hA5);
      mem_chk("file after stall", 12'h010, 8'h01);
      rdc("status stall", isx_pkg::REG_STATUS, 32'h22);
      done("busy stall");
      wrap_up();
   end

   // ==========================================================
   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #100000;
      err_total++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule

/* verilog/isx_exec.sv */
// Execution unit for increment-skip-if-nonzero and OR-literal-into-accumulator
//
// Behaviour
// RQ1: Increment-skip op reads the addressed file register, adds one, flags untouched.
// RQ2: Direction bit clear writes sum to accumulator; set writes back to file register.
// RQ3: Nonzero sum discards the fetched next instruction; one no-operation cycle follows.
// RQ4: Skipping a two-word instruction costs two no-operation cycles, three in total.
// RQ5: Access bit clear uses access bank; set uses bank select value for bank.
// RQ6: Access clear, extended set on, address at most 5Fh: indexed literal offset.
// RQ7: OR-literal op ORs the literal into the accumulator in one cycle.
// RQ8: OR-literal updates negative from bit 7 and zero flag; others unchanged.
`timescale 1ns/1ps
module isx_exec
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic busy
);

   isx_pkg::isx_state_t state;
   isx_pkg::isx_dec_t dec;
   logic [1:0] q, nop_left, last_nops;
   logic [15:0] instr, next_word;
   logic [7:0] acc, flags, result, ram_wdata, ram_rdata, or_result;
   logic [3:0] bank_select_register_value;
   logic [11:0] index_base, maddr, exec_addr, ram_addr, idx_sum;
   logic ext_en, skip_taken, illegal, indexed, take, stall, ram_we, exec_last;
   logic [31:0] next_readdata;

   // ==========================================================
   // Bus slave
   // Writes wait while an instruction runs so the register state stays coherent
   assign stall = avs_write && (state != isx_pkg::ST_IDLE);
   assign take = (avs_read || avs_write) && avs_waitrequest && !stall;
   assign exec_last = (state == isx_pkg::ST_EXEC) && (q == isx_pkg::Q_LAST);

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !take;
   end

   always_comb
   begin
      next_readdata = '0;
      case (avs_address)
         isx_pkg::REG_INSTR: next_readdata[15:0] = instr;
         isx_pkg::REG_NEXT: next_readdata[15:0] = next_word;
         isx_pkg::REG_ACC: next_readdata[7:0] = acc;
         isx_pkg::REG_FLAGS: next_readdata[7:0] = flags;
         isx_pkg::REG_BANK: next_readdata[3:0] = bank_select_register_value;
         isx_pkg::REG_INDEX: next_readdata[11:0] = index_base;
         isx_pkg::REG_CTRL: next_readdata[isx_pkg::CTRL_EXT] = ext_en;
         isx_pkg::REG_STATUS:
         begin
            next_readdata[isx_pkg::ST_BUSY] = busy;
            next_readdata[isx_pkg::ST_SKIP] = skip_taken;
            next_readdata[isx_pkg::ST_ILLEGAL] = illegal;
            next_readdata[isx_pkg::ST_INDEXED] = indexed;
            next_readdata[isx_pkg::ST_CYC_LO +: 2] = last_nops + isx_pkg::CYC_ONE;
         end
         isx_pkg::REG_MADDR: next_readdata[11:0] = maddr;
         isx_pkg::REG_MDATA: next_readdata[7:0] = ram_rdata;
         default: next_readdata = '0;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         avs_readdata <= '0;
      else if (take && avs_read)
         avs_readdata <= next_readdata;
   end

   // Software-owned configuration
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         next_word <= isx_pkg::RST_WORD;
         bank_select_register_value <= isx_pkg::RST_BYTE[3:0];
         index_base <= isx_pkg::RST_ADDR;
         ext_en <= 1'b0;
         maddr <= isx_pkg::RST_ADDR;
      end
      else if (take && avs_write && avs_byteenable[0])
      begin
         case (avs_address)
            isx_pkg::REG_NEXT: next_word <= avs_writedata[15:0];
            isx_pkg::REG_BANK: bank_select_register_value <= avs_writedata[3:0];
            isx_pkg::REG_INDEX: index_base <= avs_writedata[11:0];
            isx_pkg::REG_CTRL: ext_en <= avs_writedata[isx_pkg::CTRL_EXT];
            isx_pkg::REG_MADDR: maddr <= avs_writedata[11:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state <= isx_pkg::ST_IDLE;
         q <= isx_pkg::Q_FIRST;
         nop_left <= '0;
         instr <= isx_pkg::RST_WORD;
         busy <= 1'b0;
      end
      else
      begin
         case (state)
            isx_pkg::ST_IDLE:
            begin
               q <= isx_pkg::Q_FIRST;
               if (take && avs_write && avs_address == isx_pkg::REG_INSTR && avs_byteenable[0])
               begin
                  instr <= avs_writedata[15:0];
                  state <= isx_pkg::ST_EXEC;
                  busy <= 1'b1;
               end
            end
            isx_pkg::ST_EXEC:
            begin
               q <= q + 2'h1;
               if (q == isx_pkg::Q_LAST)
               begin
                  if (dec.is_inc && result != isx_pkg::RST_BYTE) // RQ3
                  begin
                     state <= isx_pkg::ST_FLUSH;
                     nop_left <= dec.two_word_next ? isx_pkg::NOP_TWO : isx_pkg::NOP_ONE; // RQ4
                  end
                  else
                  begin
                     state <= isx_pkg::ST_IDLE;
                     busy <= 1'b0;
                  end
               end
            end
            isx_pkg::ST_FLUSH:
            begin
               q <= q + 2'h1;
               if (q == isx_pkg::Q_LAST)
               begin
                  nop_left <= nop_left - 2'h1;
                  if (nop_left == isx_pkg::NOP_ONE)
                  begin
                     state <= isx_pkg::ST_IDLE;
                     busy <= 1'b0;
                  end
               end
            end
            default:
            begin
               state <= isx_pkg::ST_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Decode and operand address (Q1)
   assign idx_sum = index_base + {4'h0, instr[7:0]};

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         dec <= '0;
         exec_addr <= isx_pkg::RST_ADDR;
         indexed <= 1'b0;
         illegal <= 1'b0;
      end
      else if (state == isx_pkg::ST_EXEC && q == isx_pkg::Q_FIRST)
      begin
         dec.is_inc <= instr[15:10] == isx_pkg::OPC_INC_SKIP;
         dec.is_or <= instr[15:8] == isx_pkg::OPC_OR_LIT;
         dec.dest <= instr[9];
         dec.access <= instr[8];
         dec.lit <= instr[7:0];
         dec.two_word_next <= next_word[15:12] == isx_pkg::OPC_TWO_A
            || next_word[15:10] == isx_pkg::OPC_TWO_B;
         illegal <= !(instr[15:10] == isx_pkg::OPC_INC_SKIP
            || instr[15:8] == isx_pkg::OPC_OR_LIT);
         indexed <= 1'b0;
         if (instr[8])
            exec_addr <= {bank_select_register_value, instr[7:0]}; // RQ5
         else if (ext_en && instr[7:0] <= isx_pkg::ACCESS_LIMIT)
         begin
            exec_addr <= idx_sum; // RQ6
            indexed <= 1'b1;
         end
         else if (instr[7:0] <= isx_pkg::ACCESS_LIMIT)
            exec_addr <= {4'h0, instr[7:0]}; // RQ5
         else
            exec_addr <= {isx_pkg::ACCESS_HIGH_BANK, instr[7:0]}; // RQ5
      end
   end

   // ==========================================================
   // Datapath (Q2 read, Q3 process, Q4 write)
   // The bus owns the memory port only while idle
   assign ram_addr = (state == isx_pkg::ST_IDLE) ? maddr : exec_addr;
   assign ram_we = (exec_last && dec.is_inc && dec.dest) // RQ2
      || (take && avs_write && avs_address == isx_pkg::REG_MDATA && avs_byteenable[0]);
   assign ram_wdata = (state == isx_pkg::ST_IDLE) ? avs_writedata[7:0] : result;
   assign or_result = acc | dec.lit;

   isx_file_ram u_ram
   (
      .ref_clk(ref_clk),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         result <= isx_pkg::RST_BYTE;
      else if (state == isx_pkg::ST_EXEC && q == isx_pkg::Q_PROC && dec.is_inc)
         result <= ram_rdata + 8'h01; // RQ1
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         acc <= isx_pkg::RST_BYTE;
      else if (exec_last && dec.is_inc && !dec.dest)
         acc <= result; // RQ2
      else if (exec_last && dec.is_or)
         acc <= or_result; // RQ7
      else if (take && avs_write && avs_address == isx_pkg::REG_ACC && avs_byteenable[0])
         acc <= avs_writedata[7:0];
   end

   // Increment-skip leaves flags alone; only OR-literal and software change them
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         flags <= isx_pkg::RST_BYTE;
      else if (exec_last && dec.is_or)
      begin
         flags[isx_pkg::FLAG_N] <= or_result[7]; // RQ8
         flags[isx_pkg::FLAG_Z] <= or_result == isx_pkg::RST_BYTE; // RQ8
      end
      else if (take && avs_write && avs_address == isx_pkg::REG_FLAGS && avs_byteenable[0])
         flags <= avs_writedata[7:0];
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         skip_taken <= 1'b0;
         last_nops <= '0;
      end
      else if (exec_last)
      begin
         skip_taken <= dec.is_inc && result != isx_pkg::RST_BYTE;
         last_nops <= !(dec.is_inc && result != isx_pkg::RST_BYTE) ? 2'h0
            : dec.two_word_next ? isx_pkg::NOP_TWO : isx_pkg::NOP_ONE;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_skip_one;
      exec_last && dec.is_inc && result != isx_pkg::RST_BYTE && !dec.two_word_next;
   endsequence
   sequence s_skip_two;
      exec_last && dec.is_inc && result != isx_pkg::RST_BYTE && dec.two_word_next;
   endsequence
   sequence s_one_nop;
      (state == isx_pkg::ST_FLUSH)[*4];
   endsequence
   property p_inc_flags_hold; // RQ1
      exec_last && dec.is_inc |=> $stable(flags);
   endproperty
   a_inc_flags_hold: assert property (p_inc_flags_hold) else $error("flags changed"); // RQ1
   property p_inc_dest; // RQ2
      exec_last && dec.is_inc |-> (ram_we == dec.dest) ##1 (dec.dest || acc == $past(result));
   endproperty
   a_inc_dest: assert property (p_inc_dest) else $error("wrong destination"); // RQ2
   property p_skip_one; // RQ3
      s_skip_one |=> s_one_nop ##1 (state == isx_pkg::ST_IDLE && !busy);
   endproperty
   a_skip_one: assert property (p_skip_one) else $error("single skip length wrong"); // RQ3
   property p_skip_two; // RQ4
      s_skip_two |=> s_one_nop ##1 s_one_nop ##1 (state == isx_pkg::ST_IDLE);
   endproperty
   a_skip_two: assert property (p_skip_two) else $error("double skip length wrong"); // RQ4
   property p_bank_addr; // RQ5
      state == isx_pkg::ST_EXEC && q == isx_pkg::Q_READ && instr[8]
         |-> exec_addr == {bank_select_register_value, instr[7:0]};
   endproperty
   a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong"); // RQ5
   property p_indexed_addr; // RQ6
      state == isx_pkg::ST_EXEC && q == isx_pkg::Q_READ && !instr[8] && ext_en
         && instr[7:0] <= isx_pkg::ACCESS_LIMIT |-> exec_addr == idx_sum && indexed;
   endproperty
   a_indexed_addr: assert property (p_indexed_addr) else $error("indexed address wrong"); // RQ6
   property p_or_acc; // RQ7
      exec_last && dec.is_or |=> acc == ($past(acc) | $past(instr[7:0])) ##1 !busy;
   endproperty
   a_or_acc: assert property (p_or_acc) else $error("OR result wrong"); // RQ7
   property p_or_flags; // RQ8
      exec_last && dec.is_or |=> flags[isx_pkg::FLAG_N] == acc[7]
         && flags[isx_pkg::FLAG_Z] == (acc == isx_pkg::RST_BYTE)
         && {flags[7:5], flags[3], flags[1:0]}
         == $past({flags[7:5], flags[3], flags[1:0]});
   endproperty
   a_or_flags: assert property (p_or_flags) else $error("OR flags wrong"); // RQ8

endmodule

/* verilog/isx_file_ram.sv */
// File register memory: 16 banks of 256 bytes, synchronous read and write
`timescale 1ns/1ps
module isx_file_ram
(
   input wire logic ref_clk,
   input wire logic we,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   logic [7:0] mem [0:4095];

   // ==========================================================
   // Storage
   always_ff @(posedge ref_clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end

endmodule
